// [design/ivt_top.sv]
// Interrupt vector unit with two universal timers behind an APB slave.
// Summary of operation
// - Vector registers are combinational priority encodings of their status registers.
// - Valid flag reads one exactly when any status bit is set.
// - A valid vector read clears the status bit it reports.
// - Vector equals index of highest set status bit.
// - Any vector read freezes its interrupt controller.
// - Any vector write releases the freeze; data is ignored.
// - Request lines are sampled on rising edges; a one-to-zero change is an event.
// - Transfer exception interrupts also capture the master frame into a register.
// - Timer one decrements once per 240 clocks.
// - Timer two decrements once per 3 clocks.
// - Each timer is a 16-bit down-counter with auto reload and manual clear.
// - On expiry an active timer pulses low three clocks and interrupts.
// - Timer one expiry can start master frame transmission when enabled.
// - Both timers deliver expiry interrupts into the interrupt logic.
// - Each timer has a count register and a reload register.
// - Shared timer control register holds run and clear bits per timer.
// - Unmasked pending interrupts enter status only while not frozen.
// - Writing zero clears a status bit, writing one leaves it.
// - Timer with run bit cleared halts with no pulse or interrupt.
// - Writing zero to clear bit zeroes count; active timers expire and reload.
//
// The APB slave port is this design's own decision.
module ivt_top
  import ivt_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt sources and master frame data.
  input  wire logic [3:0]  extIrq_n,
  input  wire logic [15:0] lowEvents,
  input  wire logic [15:0] masterFrame,
  // Timer and controller outputs.
  output logic             timerOnePulse_n,
  output logic             timerTwoPulse_n,
  output logic             timedFrameStart,
  output logic             irqOut
);
  typedef struct packed {
    logic [2:0][3:0] sync;
    logic [3:0]      extLast;
    logic [15:0]     ctrl;
    logic [15:0]     maskLow;
    logic [15:0]     maskHigh;
    logic [15:0]     reload1;
    logic [15:0]     reload2;
    logic [15:0]     frameCopy;
    logic            timedSend;
    logic [31:0]     rdata;
  } ivt_top_s;

  ivt_top_s    state_ff;
  ivt_top_s    nxt_state;
  logic        acc;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic [15:0] wr16;
  logic [15:0] statusLow;
  logic [15:0] statusHigh;
  logic [15:0] vecLow;
  logic [15:0] vecHigh;
  logic [15:0] count1;
  logic [15:0] count2;
  logic        exp1;
  logic        exp2;
  logic [3:0]  extFall;
  logic [15:0] highEvents;
  logic        frzLow;
  logic        frzHigh;

  assign acc   = psel && penable;
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;
  assign wr16  = pwdata[15:0];

  always_comb begin
    unique case (paddr)
      STATUS_LOW_ADDR, STATUS_HIGH_ADDR, VECTOR_LOW_ADDR, VECTOR_HIGH_ADDR, MASK_LOW_ADDR, MASK_HIGH_ADDR,
      TIMER_CTRL_ADDR, TIMER1_COUNT_ADDR, TIMER1_RELOAD_ADDR, TIMER2_COUNT_ADDR, TIMER2_RELOAD_ADDR,
      FRAME_COPY_ADDR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Falling transition is seen once the second and third stages agree on zero after a one.
  assign extFall = state_ff.extLast & ~state_ff.sync[1] & ~state_ff.sync[2];

  always_comb begin
    highEvents = 16'h0000;
    highEvents[EXT_IRQ0_BIT +: 2]   = extFall[1:0];
    highEvents[14:13]               = extFall[3:2];
    highEvents[TIMER1_IRQ_BIT]      = exp1;
    highEvents[TIMER2_IRQ_BIT]      = exp2;
  end

  ivt_irq_ctrl #(
    .USED_BITS (16'hffff)
  ) u_ctl_low (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .eventIn      (lowEvents),
    .maskVal      (state_ff.maskLow),
    .statusWr     (wrAcc && paddr == STATUS_LOW_ADDR),
    .statusWrData (wr16),
    .vectorRd     (rdAcc && paddr == VECTOR_LOW_ADDR),
    .vectorWr     (wrAcc && paddr == VECTOR_LOW_ADDR),
    .statusRd     (rdAcc && paddr == STATUS_LOW_ADDR),
    .statusVal    (statusLow),
    .vectorWord   (vecLow),
    .frozen       (frzLow)
  );

  ivt_irq_ctrl #(
    .USED_BITS (STATUS_HIGH_USED)
  ) u_ctl_high (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .eventIn      (highEvents),
    .maskVal      (state_ff.maskHigh),
    .statusWr     (wrAcc && paddr == STATUS_HIGH_ADDR),
    .statusWrData (wr16),
    .vectorRd     (rdAcc && paddr == VECTOR_HIGH_ADDR),
    .vectorWr     (wrAcc && paddr == VECTOR_HIGH_ADDR),
    .statusRd     (rdAcc && paddr == STATUS_HIGH_ADDR),
    .statusVal    (statusHigh),
    .vectorWord   (vecHigh),
    .frozen       (frzHigh)
  );

  ivt_down_timer #(
    .PRESCALE (TIMER1_PRESCALE)
  ) u_timer_one (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .runEn       (state_ff.ctrl[RUN1_BIT]),
    .clearReq    (wrAcc && paddr == TIMER_CTRL_ADDR && !wr16[CLEAR1_BIT]),
    .reloadVal   (state_ff.reload1),
    .countVal    (count1),
    .expirePulse (exp1),
    .pulseOut_n  (timerOnePulse_n)
  );

  ivt_down_timer #(
    .PRESCALE (TIMER2_PRESCALE)
  ) u_timer_two (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .runEn       (state_ff.ctrl[RUN2_BIT]),
    .clearReq    (wrAcc && paddr == TIMER_CTRL_ADDR && !wr16[CLEAR2_BIT]),
    .reloadVal   (state_ff.reload2),
    .countVal    (count2),
    .expirePulse (exp2),
    .pulseOut_n  (timerTwoPulse_n)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync    = {state_ff.sync[1:0], extIrq_n};
    nxt_state.extLast = state_ff.extLast;
    for (int i = 0; i < 4; i++) begin
      if (state_ff.sync[1][i] == state_ff.sync[2][i]) begin
        nxt_state.extLast[i] = state_ff.sync[2][i];
      end
    end
    if (|(lowEvents & XFER_EXC_MASK)) begin
      nxt_state.frameCopy = masterFrame;
    end
    if (wrAcc) begin
      unique case (paddr)
        MASK_LOW_ADDR:      nxt_state.maskLow  = wr16;
        MASK_HIGH_ADDR:     nxt_state.maskHigh = wr16 & STATUS_HIGH_USED;
        TIMER_CTRL_ADDR:    nxt_state.ctrl     = (wr16 & 16'h0011) | CTRL_RESET;
        TIMER1_RELOAD_ADDR: nxt_state.reload1  = wr16;
        TIMER2_RELOAD_ADDR: nxt_state.reload2  = wr16;
        FRAME_COPY_ADDR:    nxt_state.timedSend = pwdata[16];
        default:            nxt_state.ctrl     = state_ff.ctrl;
      endcase
    end
    nxt_state.rdata = 32'h0000_0000;
    unique case (paddr)
      STATUS_LOW_ADDR:    nxt_state.rdata[15:0] = statusLow;
      STATUS_HIGH_ADDR:   nxt_state.rdata[15:0] = statusHigh;
      VECTOR_LOW_ADDR:    nxt_state.rdata[15:0] = vecLow;
      VECTOR_HIGH_ADDR:   nxt_state.rdata[15:0] = vecHigh;
      MASK_LOW_ADDR:      nxt_state.rdata[15:0] = state_ff.maskLow;
      MASK_HIGH_ADDR:     nxt_state.rdata[15:0] = state_ff.maskHigh;
      TIMER_CTRL_ADDR:    nxt_state.rdata[15:0] = state_ff.ctrl;
      TIMER1_COUNT_ADDR:  nxt_state.rdata[15:0] = count1;
      TIMER1_RELOAD_ADDR: nxt_state.rdata[15:0] = state_ff.reload1;
      TIMER2_COUNT_ADDR:  nxt_state.rdata[15:0] = count2;
      TIMER2_RELOAD_ADDR: nxt_state.rdata[15:0] = state_ff.reload2;
      FRAME_COPY_ADDR:    nxt_state.rdata = {15'h0000, state_ff.timedSend, state_ff.frameCopy};
      default:            nxt_state.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff      <= '0;
      state_ff.ctrl <= CTRL_RESET;
      state_ff.sync <= '1;
      state_ff.extLast <= 4'hf;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Read data is taken combinationally in the access cycle so the answer needs no wait state.
  assign prdata  = (rdAcc && mapped) ? nxt_state.rdata : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign timedFrameStart = exp1 && state_ff.timedSend;
  assign irqOut  = (|statusLow) || (|statusHigh);

  // Timed frame start only ever rides on a timer one expiry.
  frame_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    timedFrameStart |-> (state_ff.timedSend && !timerOnePulse_n ##1 !timerOnePulse_n))
    else $error("frame start without timer one expiry");

  // A falling request line needs two agreeing low samples and lands in status two cycles on.
  ext_sync_a: assert property (@(posedge sys_clk) disable iff (reset)
    extFall[0] |-> !$past(extIrq_n[0], 2) && !$past(extIrq_n[0], 3))
    else $error("external fall without two low samples");
  ext_event_a: assert property (@(posedge sys_clk) disable iff (reset)
    extFall[0] |-> ##2 (statusHigh[EXT_IRQ0_BIT] || $past(frzHigh) || !$past(state_ff.maskHigh[EXT_IRQ0_BIT])))
    else $error("external fall lost");

  // Timer expiries land in the high status register unless it is frozen or masked.
  t1_irq_a: assert property (@(posedge sys_clk) disable iff (reset)
    exp1 |-> ##2 (statusHigh[TIMER1_IRQ_BIT] || $past(frzHigh) || !$past(state_ff.maskHigh[TIMER1_IRQ_BIT])))
    else $error("timer one interrupt lost");
  t2_irq_a: assert property (@(posedge sys_clk) disable iff (reset)
    exp2 |-> ##2 (statusHigh[TIMER2_IRQ_BIT] || $past(frzHigh) || !$past(state_ff.maskHigh[TIMER2_IRQ_BIT])))
    else $error("timer two interrupt lost");

  // Exception events take a copy of the master frame at once.
  frame_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
    (|(lowEvents & XFER_EXC_MASK)) |=> (state_ff.frameCopy == $past(masterFrame)))
    else $error("master frame not captured");

  // Run bits follow the write, and clear bits always read back as one.
  ctrl_run_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wrAcc && paddr == TIMER_CTRL_ADDR)
      |=> (state_ff.ctrl[RUN1_BIT] == $past(wr16[RUN1_BIT])) && (state_ff.ctrl[RUN2_BIT] == $past(wr16[RUN2_BIT])))
    else $error("timer run bits not written");
  clear_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdAcc && paddr == TIMER_CTRL_ADDR) |-> prdata[CLEAR1_BIT] && prdata[CLEAR2_BIT])
    else $error("timer clear bits not read as one");

  // Clearing a halted timer leaves it silent at zero; clearing a running one expires and reloads.
  idle_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wrAcc && paddr == TIMER_CTRL_ADDR && !wr16[CLEAR2_BIT] && !state_ff.ctrl[RUN2_BIT])
      |=> (count2 == 16'h0000) && !exp2)
    else $error("halted timer clear not silent");
  run_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wrAcc && paddr == TIMER_CTRL_ADDR && !wr16[CLEAR1_BIT] && state_ff.ctrl[RUN1_BIT])
      |=> exp1 && (count1 == $past(state_ff.reload1)))
    else $error("running timer clear did not reload");
  halt_one_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!state_ff.ctrl[RUN1_BIT] && !(wrAcc && paddr == TIMER_CTRL_ADDR)) |=> $stable(count1))
    else $error("halted timer one count moved");
  halt_two_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!state_ff.ctrl[RUN2_BIT] && !(wrAcc && paddr == TIMER_CTRL_ADDR)) |=> $stable(count2))
    else $error("halted timer two count moved");

  // Vector reads return the top set bit, or zero with nothing set.
  vec_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdAcc && paddr == VECTOR_LOW_ADDR && statusLow[15]) |-> prdata[3:0] == 4'hf)
    else $error("top priority vector wrong");
  vec_high_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdAcc && paddr == VECTOR_HIGH_ADDR && statusHigh[15]) |-> prdata[3:0] == 4'hf)
    else $error("high top priority vector wrong");
  vec_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdAcc && paddr == VECTOR_LOW_ADDR && statusLow == 16'h0000) |-> prdata == 32'h0000_0000)
    else $error("empty vector not zero");

  // Status reads freeze, unused high bits stay clear, and refused accesses return no data.
  status_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdAcc && paddr == STATUS_LOW_ADDR) |=> frzLow)
    else $error("status read did not freeze");
  unused_high_a: assert property (@(posedge sys_clk) disable iff (reset)
    statusHigh[6:3] == 4'h0)
    else $error("unused high status bit set");
  unmapped_a: assert property (@(posedge sys_clk) disable iff (reset)
    (acc && !mapped) |-> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
endmodule : ivt_top

// [design/ivt_pkg.sv]
// Package of register offsets, field positions, reset values and timing counts for the vector and timer block.
package ivt_pkg;
  localparam logic [11:0] STATUS_LOW_ADDR  = 12'hfc0;
  localparam logic [11:0] STATUS_HIGH_ADDR = 12'hfc4;
  localparam logic [11:0] VECTOR_LOW_ADDR  = 12'hfc8;
  localparam logic [11:0] VECTOR_HIGH_ADDR = 12'hfcc;
  localparam logic [11:0] MASK_LOW_ADDR    = 12'hfb8;
  localparam logic [11:0] MASK_HIGH_ADDR   = 12'hfbc;
  localparam logic [11:0] TIMER_CTRL_ADDR  = 12'hf80;
  localparam logic [11:0] TIMER1_COUNT_ADDR  = 12'hf84;
  localparam logic [11:0] TIMER1_RELOAD_ADDR = 12'hf88;
  localparam logic [11:0] TIMER2_COUNT_ADDR  = 12'hf8c;
  localparam logic [11:0] TIMER2_RELOAD_ADDR = 12'hf90;
  localparam logic [11:0] FRAME_COPY_ADDR    = 12'hf94;
  localparam int VALID_BIT     = 8;
  localparam int RUN1_BIT      = 0;
  localparam int CLEAR1_BIT    = 1;
  localparam int RUN2_BIT      = 4;
  localparam int CLEAR2_BIT    = 5;
  localparam int TIMER1_IRQ_BIT = 2;
  localparam int TIMER2_IRQ_BIT = 15;
  localparam int EXT_IRQ0_BIT  = 0;
  localparam logic [15:0] XFER_EXC_MASK = 16'hf180;
  localparam logic [15:0] CTRL_RESET   = 16'h0022;
  localparam logic [15:0] STATUS_HIGH_USED = 16'hff87;
  localparam int CLK_MHZ       = 200;
  localparam int TIMER1_RES_NS = 10000;
  localparam int TIMER2_RES_NS = 125;
  localparam int PULSE_NS      = 15;
  localparam int TIMER1_PRESCALE = 240;
  localparam int TIMER2_PRESCALE = 3;
  localparam int PULSE_CYCLES  = 3;
endpackage : ivt_pkg

// [design/ivt_down_timer.sv]
// Sixteen-bit prescaled down-counter with reload, clear and a three-cycle active-low pulse.
module ivt_down_timer
  import ivt_pkg::*;
#(
  parameter int PRESCALE = 240
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Control.
  input  wire logic        runEn,
  input  wire logic        clearReq,
  input  wire logic [15:0] reloadVal,
  // Results.
  output logic      [15:0] countVal,
  output logic             expirePulse,
  output logic             pulseOut_n
);
  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  pre;
    logic [1:0]  pulse;
    logic        expire;
  } ivt_tmr_s;

  ivt_tmr_s state_ff;
  ivt_tmr_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.expire = 1'b0;
    if (state_ff.pulse != 2'h0) begin
      nxt_state.pulse = state_ff.pulse - 2'h1;
    end
    if (clearReq) begin
      // Forcing zero on an active timer expires and reloads at once; idle stays at zero silently.
      nxt_state.pre = 8'h00;
      if (runEn) begin
        nxt_state.count  = reloadVal;
        nxt_state.expire = 1'b1;
        nxt_state.pulse  = 2'(PULSE_CYCLES);
      end else begin
        nxt_state.count = 16'h0000;
      end
    end else if (runEn) begin
      if (state_ff.pre == 8'(PRESCALE - 1)) begin
        nxt_state.pre = 8'h00;
        if (state_ff.count <= 16'h0001) begin
          nxt_state.count  = reloadVal;
          nxt_state.expire = 1'b1;
          nxt_state.pulse  = 2'(PULSE_CYCLES);
        end else begin
          nxt_state.count = state_ff.count - 16'h0001;
        end
      end else begin
        nxt_state.pre = state_ff.pre + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign countVal    = state_ff.count;
  assign expirePulse = state_ff.expire;
  assign pulseOut_n  = (state_ff.pulse == 2'h0);

  pulse_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(expirePulse) |-> !pulseOut_n [*3] ##1 (pulseOut_n || expirePulse))
    else $error("timer pulse not three cycles");
  halt_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!runEn && !clearReq) |=> !expirePulse)
    else $error("halted timer expired");
  reload_same_a: assert property (@(posedge sys_clk) disable iff (reset)
    expirePulse |-> countVal == $past(reloadVal))
    else $error("timer did not reload on expiry");
endmodule : ivt_down_timer

// [design/ivt_irq_ctrl.sv]
// One interrupt controller: status register with freeze, priority-encoded vector.
module ivt_irq_ctrl
  import ivt_pkg::*;
#(
  parameter logic [15:0] USED_BITS = 16'hffff
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Events and mask.
  input  wire logic [15:0] eventIn,
  input  wire logic [15:0] maskVal,
  // Software access.
  input  wire logic        statusWr,
  input  wire logic [15:0] statusWrData,
  input  wire logic        vectorRd,
  input  wire logic        vectorWr,
  input  wire logic        statusRd,
  // Results.
  output logic      [15:0] statusVal,
  output logic      [15:0] vectorWord,
  output logic             frozen
);
  typedef struct packed {
    logic [15:0] pend;
    logic [15:0] status;
    logic        frz;
  } ivt_ctl_s;

  ivt_ctl_s state_ff;
  ivt_ctl_s nxt_state;
  logic [3:0] vecCode;
  logic       vecValid;

  always_comb begin
    vecCode = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (state_ff.status[i]) begin
        vecCode = 4'(i);
      end
    end
    vecValid = |state_ff.status;
  end

  // Vector word is pure logic on the status register; zero code when nothing is set.
  assign vectorWord = {7'h00, vecValid, 4'h0, vecValid ? vecCode : 4'h0};

  always_comb begin
    logic [15:0] clr;
    clr = 16'h0000;
    nxt_state = state_ff;
    nxt_state.pend = state_ff.pend | (eventIn & USED_BITS);
    if (statusWr) begin
      clr = ~statusWrData;
    end
    if (vectorRd && vecValid) begin
      clr[vecCode] = 1'b1;
    end
    nxt_state.status = state_ff.status & ~clr;
    if (!state_ff.frz) begin
      nxt_state.status = nxt_state.status | (state_ff.pend & maskVal);
      nxt_state.pend   = (state_ff.pend & ~maskVal) | (eventIn & USED_BITS);
    end
    if (vectorRd || statusRd) begin
      nxt_state.frz = 1'b1;
    end else if (vectorWr) begin
      nxt_state.frz = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign statusVal = state_ff.status;
  assign frozen    = state_ff.frz;

  read_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
    vectorRd |=> frozen)
    else $error("vector read did not freeze");
  write_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    (vectorWr && !vectorRd && !statusRd) |=> !frozen)
    else $error("vector write did not release");
  // A pending copy of the same bit merging in that cycle wins over the clear.
  read_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (vectorRd && vecValid && !state_ff.pend[vecCode]) |=> !statusVal[$past(vecCode)])
    else $error("reported status bit not cleared");
  frozen_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (frozen && !statusWr && !vectorRd) |=> (statusVal == $past(statusVal)))
    else $error("frozen status changed");
  valid_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    vectorWord[VALID_BIT] == (statusVal != 16'h0000))
    else $error("valid flag wrong");
endmodule : ivt_irq_ctrl

// [verification/ivt_apb_host.sv]
// Register-bus host model that issues single APB transfers to the block.
module ivt_apb_host (
  // Clock.
  input  wire logic        sys_clk,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] rdData;
  logic        rdErr;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer; released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : ivt_apb_host

// [verification/interrupt_vector_and_timers_tb_top.sv]
// Self-checking bench for the vector and timer block.
module interrupt_vector_and_timers_tb_top
  import ivt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [15:0] ev;
    logic [31:0] first;
    logic [31:0] second;
  } ivt_row_s;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  extIrq_n;
  logic [15:0] lowEvents, masterFrame;
  logic        timerOnePulse_n, timerTwoPulse_n, timedFrameStart, irqOut;
  logic        prevP1 = 1'b1, prevP2 = 1'b1;
  int          cyc, fall1, fall1Prev, fall2, fall2Prev, cnt1, cnt2, frames, lowCnt2, lowLen2, hold;
  int          errCount, totalChecks;
  ivt_row_s    rows [4] = '{'{16'h8001, 32'h10f, 32'h100}, '{16'h4004, 32'h10e, 32'h102},
                            '{16'h0006, 32'h102, 32'h101}, '{16'h0001, 32'h100, 32'h000}};

  always #2.5 sys_clk = ~sys_clk;

  ivt_top uut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrq_n(extIrq_n), .lowEvents(lowEvents), .masterFrame(masterFrame),
    .timerOnePulse_n(timerOnePulse_n), .timerTwoPulse_n(timerTwoPulse_n),
    .timedFrameStart(timedFrameStart), .irqOut(irqOut)
  );

  ivt_apb_host host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  // Measures both timers' pulse spacing and timer two's pulse width, and counts timed frame starts.
  always @(posedge sys_clk) begin
    prevP1 <= timerOnePulse_n;
    prevP2 <= timerTwoPulse_n;
    cyc <= cyc + 1;
    if (prevP1 && !timerOnePulse_n) begin
      fall1Prev <= fall1;
      fall1 <= cyc;
      cnt1 <= cnt1 + 1;
    end
    if (prevP2 && !timerTwoPulse_n) begin
      fall2Prev <= fall2;
      fall2 <= cyc;
      cnt2 <= cnt2 + 1;
    end
    if (!timerTwoPulse_n) begin
      lowCnt2 <= lowCnt2 + 1;
    end else if (lowCnt2 != 0) begin
      lowLen2 <= lowCnt2;
      lowCnt2 <= 0;
    end
    if (timedFrameStart === 1'b1) begin
      frames <= frames + 1;
    end
  end

  task automatic testDone();
    if (errCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : testDone

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkCnt(input int got, input int exp);
    totalChecks++;
    if (got != exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkCnt

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  task automatic chkRd(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0);
    chkWord(host.rdData, exp);
  endtask : chkRd

  // One-cycle event pulse into the low status register, then time for it to land.
  task automatic pulseEv(input logic [15:0] ev);
    @(posedge sys_clk);
    lowEvents <= ev;
    @(posedge sys_clk);
    lowEvents <= 16'h0;
    repeat (3) @(posedge sys_clk);
  endtask : pulseEv

  initial begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    testDone();
  end

  initial begin
    extIrq_n = 4'hf;
    lowEvents = 16'h0;
    masterFrame = 16'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    chkRd(VECTOR_LOW_ADDR, 32'h0);
    chkRd(VECTOR_HIGH_ADDR, 32'h0);
    chkRd(TIMER_CTRL_ADDR, {16'h0, CTRL_RESET});
    chkRd(12'h000, 32'h0);
    chkWord({31'h0, host.rdErr}, 32'h1);
    wr(MASK_LOW_ADDR, 32'hffff);
    wr(MASK_HIGH_ADDR, 32'hffff);
    foreach (rows[i]) begin
      wr(STATUS_LOW_ADDR, 32'h0);
      wr(VECTOR_LOW_ADDR, 32'h0);
      pulseEv(rows[i].ev);
      chkRd(VECTOR_LOW_ADDR, rows[i].first);
      chkRd(VECTOR_LOW_ADDR, rows[i].second);
    end
    // Controller is frozen now: the event must wait in pending.
    pulseEv(16'h0010);
    chkRd(VECTOR_LOW_ADDR, 32'h0);
    wr(VECTOR_LOW_ADDR, 32'hffffffff);
    repeat (2) @(posedge sys_clk);
    chkRd(VECTOR_LOW_ADDR, 32'h104);
    wr(VECTOR_LOW_ADDR, 32'h0);
    masterFrame <= 16'h5a3c;
    pulseEv(16'h00a0);
    masterFrame <= 16'h0f0f;
    chkWord({31'h0, irqOut}, 32'h1);
    chkRd(STATUS_LOW_ADDR, 32'h00a0);
    wr(STATUS_LOW_ADDR, 32'hff7f);
    chkRd(STATUS_LOW_ADDR, 32'h0020);
    chkRd(VECTOR_LOW_ADDR, 32'h105);
    host.xfer(1'b0, FRAME_COPY_ADDR, 32'h0);
    chkWord(host.rdData & 32'hffff, 32'h5a3c);
    wr(VECTOR_HIGH_ADDR, 32'h0);
    extIrq_n <= 4'he;
    repeat (8) @(posedge sys_clk);
    extIrq_n <= 4'hf;
    repeat (4) @(posedge sys_clk);
    chkRd(VECTOR_HIGH_ADDR, 32'h100);
    wr(VECTOR_HIGH_ADDR, 32'h0);
    wr(TIMER2_RELOAD_ADDR, 32'h2);
    wr(TIMER_CTRL_ADDR, 32'h32);
    repeat (40) @(posedge sys_clk);
    chkCnt(fall2 - fall2Prev, 2 * TIMER2_PRESCALE);
    chkCnt(lowLen2, PULSE_CYCLES);
    chkRd(VECTOR_HIGH_ADDR, 32'h10f);
    wr(TIMER_CTRL_ADDR, 32'h22);
    repeat (2) @(posedge sys_clk);
    hold = cnt2;
    repeat (30) @(posedge sys_clk);
    chkCnt(cnt2 - hold, 0);
    wr(TIMER_CTRL_ADDR, 32'h02);
    chkRd(TIMER2_COUNT_ADDR, 32'h0);
    chkRd(TIMER_CTRL_ADDR, 32'h22);
    wr(TIMER1_RELOAD_ADDR, 32'h1);
    wr(FRAME_COPY_ADDR, 32'h10000);
    wr(TIMER_CTRL_ADDR, 32'h23);
    repeat (600) @(posedge sys_clk);
    chkCnt(fall1 - fall1Prev, TIMER1_PRESCALE);
    chkCnt(frames, cnt1);
    chkCnt(cnt1 > 1, 1);
    hold = cnt1;
    wr(TIMER_CTRL_ADDR, 32'h21);
    repeat (3) @(posedge sys_clk);
    chkCnt(cnt1 - hold, 1);
    chkRd(TIMER1_COUNT_ADDR, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    chkRd(TIMER_CTRL_ADDR, {16'h0, CTRL_RESET});
    chkRd(VECTOR_HIGH_ADDR, 32'h0);
    chkWord({31'h0, irqOut}, 32'h0);
    testDone();
  end
endmodule : interrupt_vector_and_timers_tb_top
